// ---- rtl/eecfg_loader.v ----
// Function
// RQ1: Words 7Ch/7Eh bits 12:0 to replay timeout.
// RQ2: Replay word bits 14:13 to training count.
// RQ3: Words 80h-86h bits 5:0 to PM control.
// RQ4: PM fields: D3-L1, L1 delay, L0s enable.
// RQ5: PM bit 6 disables receive polarity inversion.
// RQ6: PM bit 7 enables legacy VGA decode.
// RQ7: PM bits 15:8 to physical control byte.
// RQ8: PM defaults 73A1h port 0, else 33A1h.
// RQ9: Words 88h-8Eh to acknowledge latency timer.
// RQ10: Words 92h-96h to slot capability low.
// RQ11: Words 9Ah-9Eh to slot capability high.
// RQ12: Slot high defaults 0008h, 0010h, 0018h.
// RQ13: Words A0h-A6h bits 6:0 to VC1 slots.
// RQ14: VC1 word bits 15:8 to TC map.
// RQ15: Only named port and mapped bits change.
// RQ16: Loading finishes before configuration access opens.
`timescale 1ns/1ps
`default_nettype none
`include "eecfg_consts.vh"

module eecfg_loader #(
   parameter PORTS = 4
) (
   // Clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // EEPROM word stream
   input  wire        ee_valid,
   output wire        ee_ready,
   input  wire [7:0]  ee_addr,
   input  wire [15:0] ee_data,
   input  wire        ee_done,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg         pready,
   output reg  [31:0] prdata,
   output reg         pslverr,
   // Load state
   output reg         load_done
);

   ////////////////////////////////////////////////////////////////////////////
   // Word buffer

   localparam ST_IDLE  = 1'b0;
   localparam ST_APPLY = 1'b1;

   wire        bo_valid;
   wire        bo_ready;
   wire [23:0] bo_data;
   wire        buf_ready;
   wire        ee_push;
   wire        bo_pop;
   reg         ee_ready_reg;
   reg  [1:0]  occ_reg;
   reg  [1:0]  occ_next;
   reg         state_reg;
   reg         state_next;

   // The loader takes one mapped word every other cycle, so a steady stream
   // fills the buffer and the source sees back-pressure.
   assign bo_ready = (state_reg == ST_IDLE);

   eecfg_buf2 #(
      .W         (24)
   ) u_buf (
      .pclk      (pclk),
      .presetn   (presetn),
      .in_valid  (ee_push),
      .in_ready  (buf_ready),
      .in_data   ({ee_addr, ee_data}),
      .out_valid (bo_valid),
      .out_ready (bo_ready),
      .out_data  (bo_data)
   );

   // The source sees a registered ready, so the fill count is kept here
   // one step ahead to know whether the buffer will still have room.
   assign ee_push = ee_valid & ee_ready_reg & buf_ready;
   assign bo_pop  = bo_valid & bo_ready;

   always @*
   begin
      occ_next = occ_reg;
      if (ee_push && !bo_pop)
         occ_next = occ_reg + 2'd1;
      else if (bo_pop && !ee_push)
         occ_next = occ_reg - 2'd1;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         occ_reg      <= 2'd0;
         ee_ready_reg <= 1'b0;
      end
      else
      begin
         occ_reg      <= occ_next;
         ee_ready_reg <= (occ_next != 2'd2);
      end
   end

   // Ready is low in reset, so nothing is accepted before the first edge.
   assign ee_ready = ee_ready_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Word decode

   wire [7:0]  w_addr;
   wire [15:0] w_data;
   wire [4:0]  w_grp;
   wire [1:0]  w_port;
   reg  [`EC_K_NUM-1:0] kind_next;

   assign w_addr = bo_data[23:16];
   assign w_data = bo_data[15:0];
   assign w_grp  = w_addr[7:3];
   assign w_port = w_addr[2:1];

   // Word bits [2:1] name the port in every group; replay words reach only ports 2 and 3, slot words only ports 1 to 3.
   always @*
   begin
      kind_next = {`EC_K_NUM{1'b0}};
      if (!w_addr[0])
      begin
         case (w_grp)
            `EC_GRP_REPLAY:
               kind_next[`EC_K_REPLAY] = w_addr[2];            // RQ1
            `EC_GRP_PM:
               kind_next[`EC_K_PM]     = 1'b1;                 // RQ3
            `EC_GRP_ACK:
               kind_next[`EC_K_ACK]    = 1'b1;                 // RQ9
            `EC_GRP_SLOT_LO:
               kind_next[`EC_K_SLO]    = (w_port != 2'd0);     // RQ10
            `EC_GRP_SLOT_HI:
               kind_next[`EC_K_SHI]    = (w_port != 2'd0);     // RQ11
            `EC_GRP_VC1:
               kind_next[`EC_K_VC1]    = 1'b1;                 // RQ13
            default:
               kind_next = {`EC_K_NUM{1'b0}};
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Loader sequence

   reg [`EC_K_NUM-1:0] kind_reg;
   reg [1:0]           port_reg;
   reg [15:0]          data_reg;
   reg                 late_en_reg;
   reg                 bad_reg;
   reg [7:0]           cnt_reg;
   reg [7:0]           last_reg;
   wire                take;
   wire                keep;
   wire                bad_set;
   wire                bad_clr;
   wire                done_next;

   assign take = bo_valid & bo_ready;
   // After the load, late words apply only when software allows it.
   assign keep = take & (~load_done | late_en_reg);
   assign bad_set = keep & ~(|kind_next);

   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
            if (keep && (|kind_next))
               state_next = ST_APPLY;
         ST_APPLY:
            state_next = ST_IDLE;
         default:
            state_next = ST_IDLE;
      endcase
   end

   // Done only once the source has finished and nothing is in flight.
   assign done_next = ee_done & ~ee_valid & ~bo_valid & (state_reg == ST_IDLE);

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= ST_IDLE;
         kind_reg  <= {`EC_K_NUM{1'b0}};
         port_reg  <= 2'd0;
         data_reg  <= 16'h0000;
         cnt_reg   <= 8'h00;
         last_reg  <= 8'h00;
         load_done <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         if (state_reg == ST_IDLE && keep)
         begin
            kind_reg <= kind_next;
            port_reg <= w_port;
            data_reg <= w_data;
            last_reg <= w_addr;
         end
         else
            kind_reg <= {`EC_K_NUM{1'b0}};
         if (state_reg == ST_APPLY)
            cnt_reg <= cnt_reg + 8'h01;
         if (done_next)
            load_done <= 1'b1;                                    // RQ16
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Port configuration registers

   wire [32*PORTS-1:0] rd_bus;
   wire [PORTS-1:0]    hit_bus;
   wire                acc;
   wire                wr_commit;
   wire [1:0]          a_port;
   wire                a_cfg;

   assign acc       = psel & penable & pready;
   assign wr_commit = acc & pwrite;
   assign a_port    = paddr[10:9];
   assign a_cfg     = ~paddr[11];

   genvar g;
   generate
      for (g = 0; g < PORTS; g = g + 1)
      begin : g_port
         wire [`EC_K_NUM-1:0] ld_g;

         // Strobes reach only the port that the word names. RQ15
         assign ld_g = (state_reg == ST_APPLY && port_reg == g) ?
                       kind_reg : {`EC_K_NUM{1'b0}};

         eecfg_port #(
            .PM_DEF  ((g == 0) ? `EC_PM_DEF_P0 : `EC_PM_DEF_PN),   // RQ8
            .SHI_DEF ((g == 1) ? `EC_SHI_DEF_P1 :
                      (g == 2) ? `EC_SHI_DEF_P2 :
                      (g == 3) ? `EC_SHI_DEF_P3 : `EC_SHI_DEF_P0)   // RQ12
         ) u_port (
            .pclk    (pclk),
            .presetn (presetn),
            .ld      (ld_g),
            .ld_data (data_reg),
            .wr_en   (wr_commit & a_cfg & (a_port == g)),
            .off     (paddr[8:0]),
            .wr_data (pwdata),
            .rd_data (rd_bus[32*g +: 32]),
            .rd_hit  (hit_bus[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Loader control and status

   wire st_sel;
   wire ct_sel;

   assign st_sel  = (paddr == `EC_ADDR_STATUS);
   assign ct_sel  = (paddr == `EC_ADDR_CTRL);
   assign bad_clr = wr_commit & st_sel & pwdata[`EC_ST_BADADDR];

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         late_en_reg <= 1'b0;
         bad_reg     <= 1'b0;
      end
      else
      begin
         if (wr_commit && ct_sel)
            late_en_reg <= pwdata[`EC_CTRL_LATE];
         // A new bad word in the clearing cycle keeps the flag set.
         if (bad_set)
            bad_reg <= 1'b1;
         else if (bad_clr)
            bad_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB answer

   reg [31:0] rdata_next;
   reg        err_next;
   reg [31:0] st_word;

   always @*
   begin
      st_word = 32'h00000000;
      st_word[`EC_ST_DONE]    = load_done;
      st_word[`EC_ST_BADADDR] = bad_reg;
      st_word[`EC_ST_CNT_LSB +: 8]  = cnt_reg;
      st_word[`EC_ST_LAST_LSB +: 8] = last_reg;
   end

   always @*
   begin
      rdata_next = 32'h00000000;
      err_next   = 1'b0;
      if (a_cfg)
      begin
         if (hit_bus[a_port])
            rdata_next = rd_bus[32*a_port +: 32];
         else
            err_next = 1'b1;
      end
      else if (st_sel)
         rdata_next = st_word;
      else if (ct_sel)
         rdata_next = {31'h0, late_en_reg};
      else
         err_next = 1'b1;
      if (pwrite)
         rdata_next = 32'h00000000;
   end

   // Accesses wait in the access phase until the load is complete; this
   // costs nothing in normal use and keeps half-loaded values hidden.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end
      else if (psel && penable && !pready && load_done)           // RQ16
      begin
         pready  <= 1'b1;
         prdata  <= rdata_next;
         pslverr <= err_next;
      end
      else
      begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end
   end

endmodule // eecfg_loader

`default_nettype wire

// ---- include/eecfg_consts.vh ----
`ifndef EECFG_CONSTS_VH
`define EECFG_CONSTS_VH

// EEPROM word address groups, taken from word address bits [7:3].
`define EC_GRP_REPLAY   5'h0f
`define EC_GRP_PM       5'h10
`define EC_GRP_ACK      5'h11
`define EC_GRP_SLOT_LO  5'h12
`define EC_GRP_SLOT_HI  5'h13
`define EC_GRP_VC1      5'h14

// Load kinds, one-hot.
`define EC_K_REPLAY     0
`define EC_K_PM         1
`define EC_K_ACK        2
`define EC_K_SLO        3
`define EC_K_SHI        4
`define EC_K_VC1        5
`define EC_K_NUM        6

// Per-port configuration register offsets.
`define EC_OFF_LINK     9'h070
`define EC_OFF_PMCTL    9'h074
`define EC_OFF_PHY      9'h088
`define EC_OFF_TLCTL    9'h08c
`define EC_OFF_SLOT     9'h0d4
`define EC_OFF_VC1TS    9'h15c
`define EC_OFF_VC1MAP   9'h160

// Loader registers on the APB map.
`define EC_ADDR_STATUS  12'h800
`define EC_ADDR_CTRL    12'h804

// Status and control fields.
`define EC_ST_DONE      0
`define EC_ST_BADADDR   1
`define EC_ST_CNT_LSB   8
`define EC_ST_LAST_LSB  16
`define EC_CTRL_LATE    0

// Word defaults.
`define EC_PM_DEF_P0    16'h73a1
`define EC_PM_DEF_PN    16'h33a1
`define EC_SHI_DEF_P0   16'h0000
`define EC_SHI_DEF_P1   16'h0008
`define EC_SHI_DEF_P2   16'h0010
`define EC_SHI_DEF_P3   16'h0018

`endif

// ---- rtl/eecfg_buf2.v ----
`timescale 1ns/1ps
`default_nettype none

module eecfg_buf2 #(
   parameter W = 24
) (
   // Clock and reset
   input  wire         pclk,
   input  wire         presetn,
   // Fill side
   input  wire         in_valid,
   output wire         in_ready,
   input  wire [W-1:0] in_data,
   // Drain side
   output wire         out_valid,
   input  wire         out_ready,
   output wire [W-1:0] out_data
);

   reg [W-1:0] ent0_reg;
   reg [W-1:0] ent1_reg;
   reg [1:0]   cnt_reg;
   wire        push;
   wire        pop;

   assign in_ready  = (cnt_reg != 2'd2);
   assign out_valid = (cnt_reg != 2'd0);
   assign out_data  = ent0_reg;
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ent0_reg <= {W{1'b0}};
         ent1_reg <= {W{1'b0}};
         cnt_reg  <= 2'd0;
      end
      else
      begin
         // Entry 0 is always the head, so a pop shifts entry 1 down.
         if (pop)
            ent0_reg <= (cnt_reg == 2'd2) ? ent1_reg : in_data;
         else if (push && cnt_reg == 2'd0)
            ent0_reg <= in_data;
         if (push && ((cnt_reg == 2'd1 && !pop) || (cnt_reg == 2'd2)))
            ent1_reg <= in_data;
         if (push && !pop)
            cnt_reg <= cnt_reg + 2'd1;
         else if (pop && !push)
            cnt_reg <= cnt_reg - 2'd1;
      end
   end

endmodule // eecfg_buf2

`default_nettype wire

// ---- rtl/eecfg_port.v ----
`timescale 1ns/1ps
`default_nettype none
`include "eecfg_consts.vh"

module eecfg_port #(
   parameter [15:0] PM_DEF  = 16'h0000,
   parameter [15:0] SHI_DEF = 16'h0000
) (
   // Clock and reset
   input  wire                 pclk,
   input  wire                 presetn,
   // Loader strobes
   input  wire [`EC_K_NUM-1:0] ld,
   input  wire [15:0]          ld_data,
   // Register access
   input  wire                 wr_en,
   input  wire [8:0]           off,
   input  wire [31:0]          wr_data,
   output reg  [31:0]          rd_data,
   output reg                  rd_hit
);

   localparam [31:0] LINK_RST  = {PM_DEF[7], 31'h0};
   localparam [31:0] PMCTL_RST = {17'h0, PM_DEF[6], PM_DEF[5:0], 8'h00};
   localparam [31:0] PHY_RST   = {PM_DEF[15:8], 24'h0};
   localparam [31:0] SLOT_RST  = {SHI_DEF, 16'h0000};

   reg [31:0] link_reg;
   reg [31:0] pmctl_reg;
   reg [31:0] phy_reg;
   reg [31:0] tlctl_reg;
   reg [31:0] slot_reg;
   reg [31:0] vc1ts_reg;
   reg [31:0] vc1map_reg;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         link_reg   <= LINK_RST;
         pmctl_reg  <= PMCTL_RST;
         phy_reg    <= PHY_RST;
         tlctl_reg  <= 32'h00000000;
         slot_reg   <= SLOT_RST;
         vc1ts_reg  <= 32'h00000000;
         vc1map_reg <= 32'h00000000;
      end
      else if (|ld)
      begin
         // Only the mapped bits move; neighbours keep their value. RQ15
         if (ld[`EC_K_REPLAY])
         begin
            link_reg[12:0]   <= ld_data[12:0];  // RQ1
            tlctl_reg[25:24] <= ld_data[14:13]; // RQ2
         end
         if (ld[`EC_K_PM])
         begin
            pmctl_reg[13:8] <= ld_data[5:0];    // RQ3 RQ4
            pmctl_reg[14]   <= ld_data[6];      // RQ5
            link_reg[31]    <= ld_data[7];      // RQ6
            phy_reg[31:24]  <= ld_data[15:8];   // RQ7
         end
         if (ld[`EC_K_ACK])
            link_reg[30:16] <= ld_data[14:0];   // RQ9
         if (ld[`EC_K_SLO])
            slot_reg[15:0] <= ld_data;          // RQ10
         if (ld[`EC_K_SHI])
            slot_reg[31:16] <= ld_data;         // RQ11
         if (ld[`EC_K_VC1])
         begin
            vc1ts_reg[22:16] <= ld_data[6:0];   // RQ13
            vc1map_reg[7:0]  <= ld_data[15:8];  // RQ14
         end
      end
      else if (wr_en)
      begin
         case (off)
            `EC_OFF_LINK:   link_reg   <= wr_data;
            `EC_OFF_PMCTL:  pmctl_reg  <= wr_data;
            `EC_OFF_PHY:    phy_reg    <= wr_data;
            `EC_OFF_TLCTL:  tlctl_reg  <= wr_data;
            `EC_OFF_SLOT:   slot_reg   <= wr_data;
            `EC_OFF_VC1TS:  vc1ts_reg  <= wr_data;
            `EC_OFF_VC1MAP: vc1map_reg <= wr_data;
            default:        link_reg   <= link_reg;
         endcase
      end
   end

   always @*
   begin
      rd_hit  = 1'b1;
      case (off)
         `EC_OFF_LINK:   rd_data = link_reg;
         `EC_OFF_PMCTL:  rd_data = pmctl_reg;
         `EC_OFF_PHY:    rd_data = phy_reg;
         `EC_OFF_TLCTL:  rd_data = tlctl_reg;
         `EC_OFF_SLOT:   rd_data = slot_reg;
         `EC_OFF_VC1TS:  rd_data = vc1ts_reg;
         `EC_OFF_VC1MAP: rd_data = vc1map_reg;
         default:
         begin
            rd_data = 32'h00000000;
            rd_hit  = 1'b0;
         end
      endcase
   end

endmodule // eecfg_port

`default_nettype wire

// ---- tb/eecfg_ee_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module eecfg_ee_model (
   // Clock, reset and pace
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        slow,
   // Word stream
   input  wire logic        ee_ready,
   output var  logic        ee_valid,
   output var  logic [7:0]  ee_addr,
   output var  logic [15:0] ee_data,
   output var  logic        ee_done
);
   logic [23:0] q[$];
   logic        ph;
   ////////////////////////////////////////////////////////////
   // An idle stream shows inverted junk so stale words never look valid.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         {ee_valid, ee_done, ph} <= 3'h0;
         {ee_addr, ee_data} <= 24'h0;
      end
      else if (!ee_valid || ee_ready)
      begin
         ph <= !ph;
         if (q.size() != 0 && (!slow || ph))
         begin
            ee_valid <= 1'b1;
            {ee_addr, ee_data} <= q.pop_front();
         end
         else
         begin
            ee_valid <= 1'b0;
            {ee_addr, ee_data} <= ~{ee_addr, ee_data};
            ee_done <= ee_done || q.size() == 0;
         end
      end
   end
endmodule // eecfg_ee_model
`default_nettype wire

// ---- tb/eecfg_loader_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module eecfg_loader_chk (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // Word stream
   input wire logic        ee_valid,
   input wire logic        ee_ready,
   input wire logic        ee_done,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        load_done
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_wait; !load_done |-> !pready; endproperty
   a_wait: assert property (p_wait) else $error("answer before load done");
   property p_hold; load_done |=> load_done; endproperty
   a_hold: assert property (p_hold) else $error("load done dropped");
   property p_ans; psel && penable && load_done && !pready |=> pready; endproperty
   a_ans: assert property (p_ans) else $error("access not answered");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("pready too long");
   property p_acc; pready |-> $past(psel && penable); endproperty
   a_acc: assert property (p_acc) else $error("pready without access");
   property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
   a_err: assert property (p_err) else $error("bad error response");
   property p_rdz; !pready || pwrite |-> prdata == 32'h0; endproperty
   a_rdz: assert property (p_rdz) else $error("read data outside read");
   property p_fin; $rose(load_done) |-> $past(ee_done && !ee_valid); endproperty
   a_fin: assert property (p_fin) else $error("load done too early");
   c_fill: cover property (ee_valid && !ee_ready);
   c_stall: cover property (psel && penable && !load_done);
   c_err: cover property (pslverr);
   c_done: cover property ($rose(load_done));
endmodule // eecfg_loader_chk
bind eecfg_loader eecfg_loader_chk chk_u (.pclk(pclk), .presetn(presetn), .ee_valid(ee_valid),
   .ee_ready(ee_ready), .ee_done(ee_done), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pready(pready), .prdata(prdata), .pslverr(pslverr), .load_done(load_done));
`default_nettype wire

// ---- tb/eecfg_loader_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module eecfg_loader_test;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        slow = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, load_done;
   logic        ee_valid, ee_ready, ee_done;
   logic [7:0]  ee_addr;
   logic [15:0] ee_data;
   logic [31:0] x[28] = '{default: 32'h0};
   logic [11:0] of[7] = '{12'h070, 12'h074, 12'h088, 12'h08c, 12'h0d4, 12'h15c, 12'h160};
   logic [15:0] pm;
   logic [31:0] r;
   logic        e;
   int          failures = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   always #4 pclk = ~pclk;
   eecfg_ee_model ee_u (.pclk(pclk), .presetn(presetn), .slow(slow), .ee_ready(ee_ready),
      .ee_valid(ee_valid), .ee_addr(ee_addr), .ee_data(ee_data), .ee_done(ee_done));
   eecfg_loader #(.PORTS(4)) dut_u (.pclk(pclk), .presetn(presetn), .ee_valid(ee_valid),
      .ee_ready(ee_ready), .ee_addr(ee_addr), .ee_data(ee_data), .ee_done(ee_done),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .load_done(load_done));
   ////////////////////////////////////////////////////////////
   // Reference map: seven registers a port, in the order of the offset table.
   function automatic void put(input logic [7:0] a, input logic [15:0] d);
      int b;
      b = a[2:1] * 7;
      if (a == 8'h7c || a == 8'h7e)
         {x[b][12:0], x[b+3][25:24]} = {d[12:0], d[14:13]};
      else if (a[7:3] == 5'h10)
         {x[b+2][31:24], x[b][31], x[b+1][14:8]} = d;
      else if (a[7:3] == 5'h11)
         x[b][30:16] = d[14:0];
      else if (a >= 8'h92 && a <= 8'h96)
         x[b+4][15:0] = d;
      else if (a >= 8'h9a && a <= 8'h9e)
         x[b+4][31:16] = d;
      else if (a[7:3] == 5'h14)
         {x[b+6][7:0], x[b+5][22:16]} = {d[15:8], d[6:0]};
   endfunction
   function automatic void deflt();
      for (int p = 0; p < 4; p++)
      begin
         pm = (p == 0) ? 16'h73a1 : 16'h33a1;
         {x[p*7+2][31:24], x[p*7][31], x[p*7+1][14:8]} = pm;
         x[p*7+4][31:16] = 16'(p * 8);
      end
   endfunction
   task automatic cmp(input logic [31:0] ex, input logic [31:0] got);
      samples_checked++;
      if (got !== ex)
      begin
         failures++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, ex, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rv, output logic ev);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rv      = prdata;
      ev      = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] v);
      apb(1'b0, a, 32'h0, r, e);
      cmp(v, r);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      apb(1'b1, a, v, r, e);
      cmp(32'h0, {31'h0, e});
   endtask
   ////////////////////////////////////////////////////////////
   // The first read stalls until every queued word has been applied, or dropped as unmapped.
   task automatic t_load;
      rd(12'h800, 32'h0080_1503);
      for (int i = 0; i < 28; i++)
         rd(12'(i / 7 * 512) + of[i % 7], x[i]);
      $display("load test done");
   endtask
   task automatic t_apb;
      wr(12'h274, 32'hffff_ffff);
      rd(12'h274, 32'hffff_ffff);
      apb(1'b1, 12'h27c, 32'h1, r, e);
      cmp(32'h1, {31'h0, e});
      apb(1'b0, 12'h078, 32'h0, r, e);
      cmp(32'h1, {31'h0, e});
      wr(12'h800, 32'h2);
      rd(12'h800, 32'h0080_1501);
      rd(12'h804, 32'h0);
      $display("register test done");
   endtask
   // Words after loading are dropped until late apply is switched on.
   task automatic t_late;
      slow <= 1'b1;
      ee_u.q.push_back({8'ha6, 16'h5a7f});
      repeat (12) @(posedge pclk);
      rd(12'h75c, x[26]);
      wr(12'h804, 32'h1);
      ee_u.q.push_back({8'ha6, 16'h5a7f});
      ee_u.q.push_back({8'h7e, 16'h7fff});
      put(8'ha6, 16'h5a7f);
      put(8'h7e, 16'h7fff);
      repeat (12) @(posedge pclk);
      rd(12'h75c, x[26]);
      rd(12'h760, x[27]);
      rd(12'h670, x[21]);
      rd(12'h68c, x[24]);
      $display("late test done");
   endtask
   // A reset with an empty source shows the register defaults unloaded.
   task automatic t_reset;
      presetn <= 1'b0;
      x = '{default: 32'h0};
      deflt();
      repeat (3) @(posedge pclk);
      cmp(32'h0, {30'h0, ee_ready, load_done});
      presetn <= 1'b1;
      rd(12'h800, 32'h0000_0001);
      cmp(32'h3, {30'h0, ee_ready, load_done});
      for (int i = 0; i < 28; i++)
         rd(12'(i / 7 * 512) + of[i % 7], x[i]);
      $display("reset test done");
   endtask
   task automatic summarize;
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         failures++;
         summarize();
      end
   end
   initial
   begin
      deflt();
      for (int a = 8'h7c; a <= 8'ha6; a += 2)
      begin
         ee_u.q.push_back({8'(a), 8'(a) ^ 8'hc3, 8'(a)});
         put(8'(a), {8'(a) ^ 8'hc3, 8'(a)});
      end
      ee_u.q.push_back({8'h80, 16'hc4d2});
      put(8'h80, 16'hc4d2);
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_load();
      t_apb();
      t_late();
      t_reset();
      summarize();
   end
endmodule // eecfg_loader_test
`default_nettype wire
